// *** core/qhp_bus_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module qhp_bus_port (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bus_mode_strap_i,
  input wire logic irq_output_policy_strap_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic channel_a_select_chip_enable_n_i,
  input wire logic channel_b_select_low_addr_n_i,
  input wire logic channel_c_select_high_addr_n_i,
  input wire logic channel_d_select_n_i,
  input wire logic [qhp_pkg::IDX_W-1:0] register_index_lines_i,
  input wire logic [qhp_pkg::DATA_W-1:0] host_data_lines_i,
  output logic [qhp_pkg::DATA_W-1:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  input wire logic [qhp_pkg::NUM_CH-1:0] modem_control_reg_bit3_i,
  input wire logic [qhp_pkg::NUM_CH-1:0] channel_irq_pending_i,
  input wire logic [qhp_pkg::DATA_W-1:0] read_data_i,
  output qhp_pkg::qhp_access_t access_o,
  output logic [qhp_pkg::NUM_CH-1:0] channel_irq_outputs_o,
  output logic [qhp_pkg::NUM_CH-1:0] channel_irq_outputs_oe_o
);
  import qhp_pkg::*;

  qhp_pins_t pins_raw;
  qhp_pins_t pins;
  qhp_chsel_t chsel;
  logic split_mode;
  logic read_now;
  logic write_now;

  qhp_state_t state;
  qhp_state_t next_state;
  qhp_access_t access;
  qhp_access_t next_access;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] next_data_out;
  logic [NUM_CH-1:0] irq_out;
  logic [NUM_CH-1:0] next_irq_out;
  logic [NUM_CH-1:0] irq_oe;
  logic [NUM_CH-1:0] next_irq_oe;

  // One strobe low with the other high; both low is refused
  function automatic logic strobe_only(input logic mine_n, input logic other_n);
    return (mine_n == PIN_LOW) && (other_n != PIN_LOW);
  endfunction

  // Modem bit 3 at zero enables that channel's driver
  function automatic logic [NUM_CH-1:0] drive_mask(input logic [NUM_CH-1:0] bit3);
    logic [NUM_CH-1:0] m;
    m = IRQ_RESET;
    for (int i = 0; i < NUM_CH; i++) begin
      m[i] = (bit3[i] == MCR_DRIVE_VAL);
    end
    return m;
  endfunction

  // Every pin, straps included, is asynchronous to clk_sys_i
  always_comb begin
    pins_raw.bus_mode = bus_mode_strap_i;
    pins_raw.policy = irq_output_policy_strap_i;
    pins_raw.read_n = read_strobe_n_i;
    pins_raw.write_n = write_strobe_n_i;
    pins_raw.sel_n[SEL_A] = channel_a_select_chip_enable_n_i;
    pins_raw.sel_n[SEL_B] = channel_b_select_low_addr_n_i;
    pins_raw.sel_n[SEL_C] = channel_c_select_high_addr_n_i;
    pins_raw.sel_n[SEL_D] = channel_d_select_n_i;
    pins_raw.index = register_index_lines_i;
    pins_raw.data = host_data_lines_i;
  end

  // Costs two cycles on every strobe, bought for metastability safety
  qhp_sync #(
    .WIDTH($bits(qhp_pins_t)),
    .RESET_VAL(PINS_IDLE)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // Strap read after the synchroniser like any other pin
  assign split_mode = (pins.bus_mode == BUS_SPLIT);

  // Strobe pair only matters in split mode; shared mode uses the
  // chip enable plus the write line as a read/not-write level.
  always_comb begin
    chsel = decode_channel(split_mode, pins.sel_n);
    read_now = 1'b0;
    write_now = 1'b0;
    if (split_mode) begin
      if (chsel.hit && strobe_only(pins.read_n, pins.write_n)) begin
        read_now = 1'b1;
      end
      if (chsel.hit && strobe_only(pins.write_n, pins.read_n)) begin
        write_now = 1'b1;
      end
    end else begin
      // Write line as a level: high reads, low writes
      if (chsel.hit) begin
        read_now = (pins.write_n == RWN_READ);
        write_now = (pins.write_n != RWN_READ);
      end
    end
  end

  // One access per strobe; the state holds until the strobe lifts
  always_comb begin
    next_state = state;
    next_access = access;
    next_access.read = 1'b0;
    next_access.write = 1'b0;
    next_data_out = data_out;
    // Channel, index and data stay put until the next access
    unique case (state)
      ST_IDLE: begin
        if (read_now) begin
          next_state = ST_READ;
          next_access.read = 1'b1;
          next_access.channel = chsel.channel;
          next_access.index = pins.index;
          next_access.data = DATA_RESET;
        end else if (write_now) begin
          next_state = ST_WRITE;
          next_access.write = 1'b1;
          next_access.channel = chsel.channel;
          next_access.index = pins.index;
          next_access.data = pins.data;
        end
      end
      ST_READ: begin
        // Core answers in the same cycle as the read pulse
        if (access.read) begin
          next_data_out = read_data_i;
        end
        if (!read_now) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!write_now) begin
          next_state = ST_IDLE;
        end
      end
      // Unused fourth code falls back to idle
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      access <= ACCESS_IDLE;
      data_out <= DATA_RESET;
    end else begin
      state <= next_state;
      access <= next_access;
      data_out <= next_data_out;
    end
  end

  assign access_o = access;
  // Read byte holds until the next read; only the enable gates it
  assign host_data_lines_o = data_out;
  // Enable waits one cycle so stale data never reaches the bus
  assign host_data_lines_oe_o = (state == ST_READ) && !access.read && read_now;

  // Interrupt pins: per-channel active high in split mode, one combined
  // active-low request on the channel A pin in shared mode.
  always_comb begin
    next_irq_out = IRQ_RESET;
    next_irq_oe = IRQ_RESET;
    if (split_mode) begin
      next_irq_out = channel_irq_pending_i;
      if (pins.policy == POLICY_ALWAYS) begin
        next_irq_oe = ALL_ON;
      end else begin
        next_irq_oe = drive_mask(modem_control_reg_bit3_i);
      end
    end else begin
      // Policy strap is not read here; shared mode ignores it
      next_irq_out[SEL_A] = ~|channel_irq_pending_i;
      // One shared pin: driven while any channel enables its driver
      next_irq_oe[SEL_A] = |drive_mask(modem_control_reg_bit3_i);
    end
  end

  // Registered so the pins never show a half-settled pending set
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_out <= IRQ_RESET;
      irq_oe <= IRQ_RESET;
    end else begin
      irq_out <= next_irq_out;
      irq_oe <= next_irq_oe;
    end
  end

  assign channel_irq_outputs_o = irq_out;
  assign channel_irq_outputs_oe_o = irq_oe;

endmodule
`default_nettype wire

// *** core/qhp_pkg.sv ***
`default_nettype none
package qhp_pkg;

  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CH_W = 2;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [CH_W-1:0] CH_A = 2'h0;
  localparam logic [CH_W-1:0] CH_B = 2'h1;
  localparam logic [CH_W-1:0] CH_C = 2'h2;
  localparam logic [CH_W-1:0] CH_D = 2'h3;

  // Bit position of each channel select in the pin bundle
  localparam int unsigned SEL_A = 0;
  localparam int unsigned SEL_B = 1;
  localparam int unsigned SEL_C = 2;
  localparam int unsigned SEL_D = 3;

  localparam logic BUS_SPLIT = 1'b1;
  localparam logic POLICY_ALWAYS = 1'b1;
  localparam logic MCR_DRIVE_VAL = 1'b0;
  localparam logic PIN_LOW = 1'b0;
  localparam logic RWN_READ = 1'b1;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [NUM_CH-1:0] IRQ_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] ALL_ON = 4'hF;

  typedef struct packed {
    logic bus_mode;
    logic policy;
    logic read_n;
    logic write_n;
    logic [NUM_CH-1:0] sel_n;
    logic [IDX_W-1:0] index;
    logic [DATA_W-1:0] data;
  } qhp_pins_t;

  // Idle pin levels, also the synchroniser reset value
  localparam qhp_pins_t PINS_IDLE = '{
    bus_mode: 1'b1,
    policy: 1'b0,
    read_n: 1'b1,
    write_n: 1'b1,
    sel_n: 4'hF,
    index: 3'h0,
    data: 8'h00
  };

  typedef struct packed {
    logic write;
    logic read;
    logic [CH_W-1:0] channel;
    logic [IDX_W-1:0] index;
    logic [DATA_W-1:0] data;
  } qhp_access_t;

  localparam qhp_access_t ACCESS_IDLE = '{
    write: 1'b0,
    read: 1'b0,
    channel: 2'h0,
    index: 3'h0,
    data: 8'h00
  };

  typedef struct packed {
    logic hit;
    logic [CH_W-1:0] channel;
  } qhp_chsel_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } qhp_state_t;

  // Channel decode for both bus styles
  function automatic qhp_chsel_t decode_channel(input logic split,
                                                input logic [NUM_CH-1:0] sel_n);
    qhp_chsel_t r;
    r.hit = 1'b0;
    r.channel = CH_A;
    if (split == BUS_SPLIT) begin
      // Several selects low at once: lowest channel wins
      if (sel_n[SEL_A] == PIN_LOW) begin
        r.hit = 1'b1;
        r.channel = CH_A;
      end else if (sel_n[SEL_B] == PIN_LOW) begin
        r.hit = 1'b1;
        r.channel = CH_B;
      end else if (sel_n[SEL_C] == PIN_LOW) begin
        r.hit = 1'b1;
        r.channel = CH_C;
      end else if (sel_n[SEL_D] == PIN_LOW) begin
        r.hit = 1'b1;
        r.channel = CH_D;
      end
    end else begin
      r.hit = (sel_n[SEL_A] == PIN_LOW);
      r.channel = {sel_n[SEL_C], sel_n[SEL_B]};
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// *** core/qhp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module qhp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  // First stage feeds only the second stage
  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;

endmodule
`default_nettype wire

// *** dv/qhp_bus_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module qhp_bus_port_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bus_mode_strap_i,
  input wire logic irq_output_policy_strap_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic channel_a_select_chip_enable_n_i,
  input wire logic channel_b_select_low_addr_n_i,
  input wire logic channel_c_select_high_addr_n_i,
  input wire logic channel_d_select_n_i,
  input wire logic [2:0] register_index_lines_i,
  input wire logic [7:0] host_data_lines_i,
  input wire logic [7:0] host_data_lines_o,
  input wire logic host_data_lines_oe_o,
  input wire logic [3:0] modem_control_reg_bit3_i,
  input wire logic [3:0] channel_irq_pending_i,
  input wire logic [7:0] read_data_i,
  input wire qhp_pkg::qhp_access_t access_o,
  input wire logic [3:0] channel_irq_outputs_o,
  input wire logic [3:0] channel_irq_outputs_oe_o
);
  import qhp_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Strap history: straps only count once the synchroniser has caught up
  logic [3:0] md_h, po_h, next_md_h, next_po_h;
  logic split_ok, shared_ok, pol_hi, pol_lo, acc;
  always_comb begin
    next_md_h = rst_n_i ? {md_h[2:0], bus_mode_strap_i} : 4'h0;
    next_po_h = rst_n_i ? {po_h[2:0], irq_output_policy_strap_i} : 4'hF;
    split_ok = &md_h;
    shared_ok = ~|md_h;
    pol_hi = &po_h;
    pol_lo = ~|po_h;
    acc = access_o.read || access_o.write;
  end
  always_ff @(posedge clk_sys_i) begin
    md_h <= next_md_h;
    po_h <= next_po_h;
  end
  a_read_drive: assert property (access_o.read |=> host_data_lines_oe_o &&
    host_data_lines_o == $past(read_data_i)) else $error("read data not driven");
  a_write_quiet: assert property (access_o.write |=> !host_data_lines_oe_o)
    else $error("bus driven on write");
  a_read_strobe: assert property (access_o.read && split_ok |->
    !$past(read_strobe_n_i, 3) && $past(write_strobe_n_i, 3)) else $error("read without strobe");
  a_write_strobe: assert property (access_o.write && split_ok |->
    !$past(write_strobe_n_i, 3) && access_o.data == $past(host_data_lines_i, 3))
    else $error("write strobe or data wrong");
  a_index_pass: assert property (acc |-> access_o.index == $past(register_index_lines_i, 3))
    else $error("register index wrong");
  a_select_c: assert property (acc && split_ok && access_o.channel == CH_C |->
    !$past(channel_c_select_high_addr_n_i, 3)) else $error("channel C not selected");
  a_select_d: assert property (acc && split_ok && access_o.channel == CH_D |->
    !$past(channel_d_select_n_i, 3)) else $error("channel D not selected");
  a_shared_chan: assert property (acc && shared_ok |->
    !$past(channel_a_select_chip_enable_n_i, 3) && access_o.channel ==
    {$past(channel_c_select_high_addr_n_i, 3), $past(channel_b_select_low_addr_n_i, 3)})
    else $error("shared channel decode wrong");
  a_irq_always: assert property (split_ok && pol_hi |-> channel_irq_outputs_oe_o == 4'hF)
    else $error("irq not always driven");
  a_irq_modem: assert property (split_ok && pol_lo |->
    channel_irq_outputs_oe_o == ~$past(modem_control_reg_bit3_i)) else $error("irq enable wrong");
  a_oe_split: assert property (host_data_lines_oe_o && split_ok |->
    !$past(read_strobe_n_i, 2) && $past(write_strobe_n_i, 2)) else $error("bus driven without read");
  a_oe_shared: assert property (host_data_lines_oe_o && shared_ok |->
    !$past(channel_a_select_chip_enable_n_i, 2) && $past(write_strobe_n_i, 2))
    else $error("bus driven without shared read");
endmodule
bind qhp_bus_port qhp_bus_port_props i_qhp_bus_port_props (.*);
`default_nettype wire

// *** dv/qhp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module qhp_host_model (
  input wire logic clk_sys_i,
  output var qhp_pkg::qhp_pins_t pins_o
);
  import qhp_pkg::*;
  initial pins_o = PINS_IDLE;
  task automatic straps(input logic md, input logic po);
    @(posedge clk_sys_i);
    #1;
    pins_o.bus_mode = md;
    pins_o.policy = po;
  endtask
  // Released data lines invert so a stale byte never looks valid
  task automatic xfer(input logic md, input logic wr, input logic [1:0] ch,
                      input logic [2:0] ix, input logic [7:0] dt, input logic both);
    @(posedge clk_sys_i);
    #1;
    pins_o.index = ix;
    pins_o.data = wr ? dt : ~pins_o.data;
    if (md) begin
      pins_o.sel_n = ~(4'h1 << ch);
      {pins_o.read_n, pins_o.write_n} = both ? 2'b00 : (wr ? 2'b10 : 2'b01);
    end else begin
      pins_o.sel_n = {1'b1, ch, 1'b0};
      pins_o.write_n = !wr;
    end
    repeat (6) @(posedge clk_sys_i);
    #1;
    {pins_o.read_n, pins_o.write_n} = 2'b11;
    pins_o.sel_n = 4'hF;
    pins_o.data = ~pins_o.data;
    repeat (3) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// *** dv/qhp_bus_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module qhp_bus_port_tb;
  import qhp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] modem_control_reg_bit3_i = 4'h0;
  logic [3:0] channel_irq_pending_i = 4'h0;
  logic [7:0] read_data_i, host_data_lines_o, rd_exp, dt;
  logic [7:0] key = 8'h00;
  logic [3:0] channel_irq_outputs_o, channel_irq_outputs_oe_o, irq_exp;
  logic host_data_lines_oe_o, wr;
  logic rd_pend = 1'b0;
  logic [1:0] ch;
  logic [2:0] ix;
  qhp_access_t access_o, e;
  qhp_pins_t p;
  qhp_access_t exp_q[$];
  int err_count = 0;
  int samples_checked = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  // Core side answers at once from the decoded channel and index
  assign read_data_i = {access_o.channel, access_o.index, 3'h5} ^ key;
  qhp_host_model i_qhp_host_model (.clk_sys_i, .pins_o(p));
  qhp_bus_port i_qhp_bus_port (.clk_sys_i, .rst_n_i, .bus_mode_strap_i(p.bus_mode),
    .irq_output_policy_strap_i(p.policy), .read_strobe_n_i(p.read_n),
    .write_strobe_n_i(p.write_n), .channel_a_select_chip_enable_n_i(p.sel_n[0]),
    .channel_b_select_low_addr_n_i(p.sel_n[1]), .channel_c_select_high_addr_n_i(p.sel_n[2]),
    .channel_d_select_n_i(p.sel_n[3]), .register_index_lines_i(p.index),
    .host_data_lines_i(p.data), .host_data_lines_o, .host_data_lines_oe_o,
    .modem_control_reg_bit3_i, .channel_irq_pending_i, .read_data_i, .access_o,
    .channel_irq_outputs_o, .channel_irq_outputs_oe_o);
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    samples_checked++;
    if (ex !== got) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk_sys_i) begin
    if (rd_pend) begin
      chk("read_data", 16'({1'b1, rd_exp}),
          16'({host_data_lines_oe_o, host_data_lines_o}));
      rd_pend = 1'b0;
    end
    if (rst_n_i && (access_o.read || access_o.write)) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_access", 16'h0, 16'h1);
      end else begin
        e = exp_q.pop_front();
        chk("kind_ch_idx", 16'({e.write, e.read, e.channel, e.index}),
            16'({access_o.write, access_o.read, access_o.channel, access_o.index}));
        if (e.write) chk("write_data", 16'(e.data), 16'(access_o.data));
        else {rd_pend, rd_exp} = {1'b1, e.data};
      end
    end
  end
  initial begin
    void'($urandom(76411));
    key = 8'($urandom);
    repeat (8) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    for (int m = 1; m >= 0; m--) begin
      i_qhp_host_model.straps(m[0], 1'b0);
      for (int k = 0; k < 8; k++) begin
        {ch, wr} = k[2:0];
        ix = 3'($urandom);
        dt = 8'($urandom);
        exp_q.push_back('{wr, !wr, ch, ix, wr ? dt : {ch, ix, 3'h5} ^ key});
        i_qhp_host_model.xfer(m[0], wr, ch, ix, dt, 1'b0);
      end
      $display("access test done, bus mode %0d", m);
    end
    i_qhp_host_model.straps(1'b1, 1'b0);
    i_qhp_host_model.xfer(1'b1, 1'b0, CH_C, 3'h1, 8'h00, 1'b1);
    chk("pending_notes", 16'h0, 16'(exp_q.size()));
    $display("double strobe test done");
    for (int j = 0; j < 3; j++) begin
      i_qhp_host_model.straps(j != 2, j == 0);
      modem_control_reg_bit3_i = 4'($urandom);
      channel_irq_pending_i = 4'($urandom);
      repeat (6) @(posedge clk_sys_i);
      #1;
      irq_exp = ~modem_control_reg_bit3_i;
      if (j == 0) begin
        chk("irq_enable", 16'hF, 16'(channel_irq_outputs_oe_o));
        chk("irq_level", 16'(channel_irq_pending_i), 16'(channel_irq_outputs_o));
      end else if (j == 1) begin
        chk("irq_enable", 16'(irq_exp), 16'(channel_irq_outputs_oe_o));
        chk("irq_level", 16'(channel_irq_pending_i), 16'(channel_irq_outputs_o));
      end else begin
        irq_exp = {3'h0, ~&modem_control_reg_bit3_i};
        chk("irq_enable", 16'(irq_exp), 16'(channel_irq_outputs_oe_o));
        irq_exp = {3'h0, ~|channel_irq_pending_i};
        chk("irq_combined", 16'(irq_exp), 16'(channel_irq_outputs_o));
      end
    end
    $display("interrupt test done");
    summarize();
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
